// ### include/pds_pkg.sv
/*
 * shared constants of the divider control link: word layout, latch
 * selection codes, divider figures and host register map.
 * assumes nothing of its surroundings.
 */
package pds_pkg;
    // =====================================================
    // serial word layout (bit k of the word sits at index 24-k)
    localparam int WORD_W = 24;
    localparam int MAIN_W = 12;
    localparam int SWAL_W = 5;
    localparam int BOOST_W = 5;
    localparam int REFB_W = 16;
    localparam int MAIN_HI = 23; // word bits 1..12
    localparam int SWAL_HI = 11; // word bits 13..17
    localparam int BOOST_HI = 6; // word bits 18..22
    localparam int REFB_HI = 23; // word bits 1..16
    localparam int LDEN_POS = 4; // word bit 20
    localparam logic [1:0] SEL_NDIV = 2'h0;
    localparam logic [1:0] SEL_RDIV = 2'h1;
    // =====================================================
    // divider figures
    localparam logic [5:0] PRE_LOW = 6'h20; // modulus 32, 33 while swallowing
    localparam logic [1:0] REF_PRE_LAST = 2'h3; // fixed divide by 4
    localparam logic [MAIN_W-1:0] MAIN_RST = 12'h020;
    localparam logic [REFB_W-1:0] REFB_RST = 16'h0005;
    // =====================================================
    // host register map (apb, one word each)
    localparam logic [7:0] REG_TXWORD = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam int CTRL_GO = 0;
    localparam int CTRL_RUN = 1;
    localparam int STAT_BUSY = 0;
    // =====================================================
    // serial timing: 2 us minimum setup/hold at 100 ns per cycle
    localparam int CLK_NS = 100;
    localparam int SETUP_NS = 2000;
    localparam int HALF_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_LOW = 3'b001,
        H_HIGH = 3'b010,
        H_STROBE = 3'b011,
        H_GAP = 3'b100
    } pds_hstate_type;
endpackage

// ### include/pds_link_if.sv
/*
 * three-wire control link plus the power-save pin between host and
 * divider device. all wires are driven only by the host.
 */
`timescale 1ns/1ps
interface pds_link_if;
    logic ser_clk;
    logic ser_data;
    logic latch_strobe;
    logic run_n_standby; // high runs, low is standby
    modport host (output ser_clk, output ser_data, output latch_strobe, output run_n_standby);
    modport dev (input ser_clk, input ser_data, input latch_strobe, input run_n_standby);
endinterface

// ### core/pds_dev.sv
/*
 * divider device: serial latches, vco and reference dividers, phase
 * comparator, booster and unlock outputs. core_clk samples every pin
 * (link, power, vco, reference) and must run well above twice their rates.
 */
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module pds_dev
    import pds_pkg::*;
#(
    parameter int LOCK_WIN = 2
) (
    input wire logic core_clk,
    input wire logic resetn,
    pds_link_if.dev link,
    input wire logic core_pwr_ok,
    input wire logic vco_in,
    input wire logic ref_osc_in,
    output logic pump_out,
    output logic pump_oe,
    output logic booster_out,
    output logic booster_oe,
    output logic unlock_flag,
    output logic divided_vco_pulse,
    output logic divided_ref_pulse
);
    import pds_pkg::*;

    // =====================================================
    // pin sampling
    logic [6:0] pin_raw, meta_q, sync_q, prev_q;
    assign pin_raw = {core_pwr_ok, ref_osc_in, vco_in, link.run_n_standby, link.latch_strobe,
                      link.ser_data, link.ser_clk};
    // two stages before use, third for edge finding
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= 7'h00;
            sync_q <= 7'h00;
            prev_q <= 7'h00;
        end else begin
            meta_q <= pin_raw;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end
    logic sclk_rise, le_rise, le_fall, run_rise, vco_rise, ref_rise, running;
    assign sclk_rise = sync_q[0] & ~prev_q[0];
    assign le_rise = sync_q[2] & ~prev_q[2];
    assign le_fall = ~sync_q[2] & prev_q[2];
    assign running = sync_q[3] & sync_q[6];
    assign run_rise = running & ~(prev_q[3] & prev_q[6]);
    assign vco_rise = sync_q[4] & ~prev_q[4];
    assign ref_rise = sync_q[5] & ~prev_q[5];

    // =====================================================
    // shift register
    logic [WORD_W-1:0] shift_q;
    // shift on rise, strobe low only
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            shift_q <= '0;
        end else if (sclk_rise && !sync_q[2]) begin
            // msb first, newest bit at index 0
            shift_q <= {shift_q[WORD_W-2:0], sync_q[1]};
        end
    end

    // =====================================================
    // latches; kept through standby
    logic [MAIN_W-1:0] main_lat_q;
    logic [SWAL_W-1:0] swal_lat_q;
    logic [BOOST_W-1:0] boost_lat_q;
    logic [REFB_W-1:0] refb_lat_q;
    logic lden_q, wr_pend_q;
    // strobe rise loads the chosen latch
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            main_lat_q <= MAIN_RST;
            swal_lat_q <= '0;
            boost_lat_q <= '0;
            refb_lat_q <= REFB_RST;
            lden_q <= 1'b0;
        end else if (le_rise) begin
            if (shift_q[1:0] == SEL_NDIV) begin
                main_lat_q <= shift_q[MAIN_HI -: MAIN_W];
                swal_lat_q <= shift_q[SWAL_HI -: SWAL_W];
                boost_lat_q <= shift_q[BOOST_HI -: BOOST_W];
            end else if (shift_q[1:0] == SEL_RDIV) begin
                refb_lat_q <= shift_q[REFB_HI -: REFB_W];
                lden_q <= shift_q[LDEN_POS];
            end
        end
    end
    // write pending until the strobe falls
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wr_pend_q <= 1'b0;
        end else if (le_rise || le_fall) begin
            wr_pend_q <= le_rise;
        end
    end

    // =====================================================
    // vco divider: prescaler 32/33, swallow and main counters
    logic [5:0] pre_q;
    logic [SWAL_W:0] swal_q;
    logic [MAIN_W-1:0] main_q, main_act_q;
    logic [SWAL_W-1:0] swal_act_q;
    logic pre_last, swallowing, fv_q;
    assign swallowing = swal_q < {1'b0, swal_act_q};
    // 33 counts while swallowing, else 32
    assign pre_last = swallowing ? (pre_q == PRE_LOW) : (pre_q == PRE_LOW - 6'h01);
    // counts, standby reset, reload at end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pre_q <= '0;
            swal_q <= '0;
            main_q <= '0;
            main_act_q <= MAIN_RST;
            swal_act_q <= '0;
            fv_q <= 1'b0;
        end else if (!running) begin
            pre_q <= '0;
            swal_q <= '0;
            main_q <= '0;
            main_act_q <= main_lat_q;
            swal_act_q <= swal_lat_q;
            fv_q <= 1'b0;
        end else begin
            fv_q <= 1'b0;
            if (vco_rise) begin
                pre_q <= pre_last ? 6'h00 : pre_q + 6'h01;
                if (pre_last) begin
                    swal_q <= swal_q + {5'h00, swallowing};
                    if (main_q == main_act_q - 12'h001) begin
                        fv_q <= 1'b1;
                        main_q <= '0;
                        swal_q <= '0;
                        main_act_q <= main_lat_q;
                        swal_act_q <= swal_lat_q;
                    end else begin
                        main_q <= main_q + 12'h001;
                    end
                end
            end
        end
    end

    // =====================================================
    // reference divider: fixed by 4, then B
    logic [1:0] rpre_q;
    logic [REFB_W-1:0] refb_q, refb_act_q;
    logic fr_q;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rpre_q <= '0;
            refb_q <= '0;
            refb_act_q <= REFB_RST;
            fr_q <= 1'b0;
        end else if (!running) begin
            rpre_q <= '0;
            refb_q <= '0;
            refb_act_q <= refb_lat_q;
            fr_q <= 1'b0;
        end else begin
            fr_q <= 1'b0;
            if (ref_rise) begin
                rpre_q <= rpre_q + 2'h1;
                if (rpre_q == REF_PRE_LAST) begin
                    if (refb_q == refb_act_q - 16'h0001) begin
                        fr_q <= 1'b1;
                        refb_q <= '0;
                        refb_act_q <= refb_lat_q;
                    end else begin
                        refb_q <= refb_q + 16'h0001;
                    end
                end
            end
        end
    end
    assign divided_vco_pulse = fv_q;
    assign divided_ref_pulse = fr_q;

    // =====================================================
    // phase comparator; pump high when reference leads
    logic up_q, dn_q;
    // set by own pulse, both cleared together
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
        end else if (!running || ((up_q | fr_q) && (dn_q | fv_q))) begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
        end else begin
            up_q <= up_q | fr_q;
            dn_q <= dn_q | fv_q;
        end
    end
    assign pump_out = up_q;
    assign pump_oe = running & (up_q ^ dn_q);

    // =====================================================
    // lock detect: error width over a window marks a period unlocked
    logic [3:0] err_w_q;
    logic err_q, lock_q;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            err_w_q <= '0;
            err_q <= 1'b0;
            lock_q <= 1'b0;
        end else if (!running) begin
            err_w_q <= '0;
            err_q <= 1'b0;
            lock_q <= 1'b0;
        end else begin
            err_w_q <= (up_q ^ dn_q) ? ((err_w_q == 4'hf) ? err_w_q : err_w_q + 4'h1) : 4'h0;
            if (fr_q) begin
                lock_q <= ~err_q;
                err_q <= 1'b0;
            end else if (err_w_q >= 4'(LOCK_WIN)) begin
                err_q <= 1'b1;
            end
        end
    end
    // low when out of lock, disabled or standby
    assign unlock_flag = running & lden_q & lock_q;

    // =====================================================
    // booster: runs for the coded number of reference periods
    logic [BOOST_W-1:0] boost_cnt_q;
    logic boost_on_q;
    // start on run rise or strobe fall after write
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            boost_cnt_q <= '0;
            boost_on_q <= 1'b0;
        end else if (!running) begin
            boost_cnt_q <= '0;
            boost_on_q <= 1'b0;
        end else if ((run_rise || (le_fall && wr_pend_q)) && boost_lat_q != '0) begin
            boost_cnt_q <= boost_lat_q;
            boost_on_q <= 1'b1;
        end else if (boost_on_q && fr_q) begin
            boost_cnt_q <= boost_cnt_q - 5'h01;
            boost_on_q <= boost_cnt_q != 5'h01;
        end
    end
    // drives the pump direction harder while active
    assign booster_out = up_q;
    assign booster_oe = boost_on_q & running;
endmodule // pds_dev

// ### core/pds_host.sv
/*
 * host end of the control link: an apb slave whose registers hold the
 * word to send, a go bit and the run level; it shifts the word out with
 * its own divided serial clock and strobes it in. single clock domain.
 */
`timescale 1ns/1ps
module pds_host
    import pds_pkg::*;
#(
    parameter int HALF = HALF_CYC
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    pds_link_if.host link
);
    import pds_pkg::*;

    // =====================================================
    // registers
    logic [WORD_W-1:0] word_q;
    logic run_q, go_q, acc, wr;
    pds_hstate_type st_q;
    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign pready = 1'b1; // every access ends in its first access cycle
    assign pslverr = acc & ~(paddr == REG_TXWORD || paddr == REG_CTRL || paddr == REG_STATUS);
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            word_q <= '0;
            run_q <= 1'b0;
            go_q <= 1'b0;
        end else begin
            go_q <= 1'b0;
            if (wr && paddr == REG_TXWORD && st_q == H_IDLE) begin
                word_q <= pwdata[WORD_W-1:0];
            end
            if (wr && paddr == REG_CTRL) begin
                run_q <= pwdata[CTRL_RUN];
                go_q <= pwdata[CTRL_GO];
            end
        end
    end
    // read data decoded combinationally from paddr, not registered
    always_comb begin
        prdata = 32'h0000_0000;
        if (paddr == REG_TXWORD) begin
            prdata[WORD_W-1:0] = word_q;
        end else if (paddr == REG_CTRL) begin
            prdata[CTRL_RUN] = run_q;
        end else if (paddr == REG_STATUS) begin
            prdata[STAT_BUSY] = (st_q != H_IDLE) | go_q;
        end
    end

    // =====================================================
    // shifter
    logic [15:0] tick_q;
    logic [4:0] bit_q;
    logic sclk_q, sdat_q, le_q, tick_end;
    assign tick_end = tick_q == 16'(HALF - 1);
    // msb first, data on falling edge, idle low
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= H_IDLE;
            tick_q <= '0;
            bit_q <= '0;
            sclk_q <= 1'b0;
            sdat_q <= 1'b0;
            le_q <= 1'b0;
        end else begin
            tick_q <= tick_end ? 16'h0000 : tick_q + 16'h0001;
            unique case (st_q)
                H_IDLE: begin
                    tick_q <= '0;
                    if (go_q) begin
                        st_q <= H_LOW;
                        bit_q <= 5'(WORD_W - 1);
                        sdat_q <= word_q[WORD_W-1];
                    end
                end
                H_LOW: if (tick_end) begin
                    st_q <= H_HIGH;
                    sclk_q <= 1'b1;
                end
                H_HIGH: if (tick_end) begin
                    sclk_q <= 1'b0;
                    if (bit_q == 5'h00) begin
                        st_q <= H_GAP;
                        sdat_q <= 1'b0;
                    end else begin
                        st_q <= H_LOW;
                        bit_q <= bit_q - 5'h01;
                        sdat_q <= word_q[bit_q - 5'h01];
                    end
                end
                H_GAP: if (tick_end) begin
                    st_q <= H_STROBE;
                    le_q <= 1'b1;
                end
                H_STROBE: if (tick_end) begin
                    st_q <= H_IDLE;
                    le_q <= 1'b0;
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end
    assign link.ser_clk = sclk_q;
    assign link.ser_data = sdat_q;
    assign link.latch_strobe = le_q;
    assign link.run_n_standby = run_q;
endmodule // pds_host

// ### verif/pds_link_asserts.sv
/*
 * checker for the divider control link: word framing, idle levels,
 * standby outputs and divider pulse spacing.
 * assumes one core_clk domain and a host half period of >= 2 cycles.
 */
`timescale 1ns/1ps
module pds_link_asserts (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic latch_strobe,
    input wire logic run_n_standby,
    input wire logic core_pwr_ok,
    input wire logic pump_out,
    input wire logic pump_oe,
    input wire logic booster_out,
    input wire logic booster_oe,
    input wire logic unlock_flag,
    input wire logic divided_vco_pulse,
    input wire logic divided_ref_pulse
);
    // =====================================================
    // helper: serial rises counted since the last strobe
    logic sclk_q;
    logic [5:0] nrise_q;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sclk_q <= 1'h0;
            nrise_q <= 6'h00;
        end else begin
            sclk_q <= ser_clk;
            if (latch_strobe) begin
                nrise_q <= 6'h00;
            end else if (ser_clk && !sclk_q) begin
                nrise_q <= nrise_q + 6'h01;
            end
        end
    end
    // run as the device sees it; its synchroniser makes it two cycles late
    logic run_ok;
    assign run_ok = run_n_standby & core_pwr_ok;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    // =====================================================
    // link framing
    property p_word_len;
        $rose(latch_strobe) |-> nrise_q == 6'h18;
    endproperty
    a_word_len: assert property (p_word_len)
        else $error("strobe after wrong bit count");
    property p_data_hold;
        ser_clk |-> $stable(ser_data);
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("data moved while serial clock high");
    property p_clk_half;
        $rose(ser_clk) |-> ser_clk [*2];
    endproperty
    a_clk_half: assert property (p_clk_half)
        else $error("serial clock high too short");
    property p_no_shift_strobe;
        ser_clk |-> !latch_strobe;
    endproperty
    a_no_shift_strobe: assert property (p_no_shift_strobe)
        else $error("strobe high while shifting");
    property p_idle_low;
        $fell(latch_strobe) |-> !ser_clk && !ser_data;
    endproperty
    a_idle_low: assert property (p_idle_low)
        else $error("link lines not low after strobe");
    // =====================================================
    // device outputs
    property p_standby_quiet;
        !run_n_standby [*6] |-> !pump_oe && !booster_oe && !unlock_flag;
    endproperty
    a_standby_quiet: assert property (p_standby_quiet)
        else $error("outputs active in standby");
    property p_vco_space;
        divided_vco_pulse |=> !divided_vco_pulse [*8];
    endproperty
    a_vco_space: assert property (p_vco_space)
        else $error("vco pulses too close");
    property p_ref_space;
        divided_ref_pulse |=> !divided_ref_pulse [*8];
    endproperty
    a_ref_space: assert property (p_ref_space)
        else $error("reference pulses too close");
    property p_pump_up;
        divided_ref_pulse && !divided_vco_pulse && !pump_oe && $past(run_ok) &&
            $past(run_ok, 2) |=> pump_oe && pump_out && booster_out;
    endproperty
    a_pump_up: assert property (p_pump_up)
        else $error("pump not driven up after leading reference pulse");
    property p_lock_run;
        $rose(unlock_flag) |-> $past(run_n_standby, 4);
    endproperty
    a_lock_run: assert property (p_lock_run)
        else $error("lock shown without running");
    c_strobe: cover property ($rose(latch_strobe));
    c_boost: cover property ($rose(booster_oe));
    c_lock: cover property ($rose(unlock_flag));
endmodule // pds_link_asserts

// ### verif/test_pll_divider_serial_control.sv
/*
 * bench: apb host end and divider device joined by the link interface.
 * assumes 10 mhz core_clk; vco and reference stand-ins run 8 cycles a period.
 */
`timescale 1ns/1ps
module test_pll_divider_serial_control;
    import pds_pkg::*;
    logic core_clk = 1'h0;
    logic resetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, pump_out, pump_oe, booster_out, booster_oe, unlock_flag;
    logic divided_vco_pulse, divided_ref_pulse;
    logic core_pwr_ok = 1'h1;
    logic vco_in = 1'h0;
    logic ref_osc_in = 1'h0;
    logic [2:0] osc_q = 3'h0;
    logic [31:0] rd;
    logic err;
    int n;
    int num_errors = 0;
    int n_checks = 0;
    // =====================================================
    // clock and same-phase oscillators, so matched ratios lock
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        osc_q <= osc_q + 3'h1;
        vco_in <= osc_q[2];
        ref_osc_in <= osc_q[2];
    end
    pds_link_if link_if();
    pds_host #(.HALF(4)) pds_host_i (.core_clk, .resetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .link(link_if.host));
    pds_dev pds_dev_i (.core_clk, .resetn, .link(link_if.dev), .core_pwr_ok, .vco_in,
        .ref_osc_in, .pump_out, .pump_oe, .booster_out, .booster_oe, .unlock_flag,
        .divided_vco_pulse, .divided_ref_pulse);
    pds_link_asserts pds_link_asserts_i (.core_clk, .resetn, .ser_clk(link_if.ser_clk),
        .ser_data(link_if.ser_data), .latch_strobe(link_if.latch_strobe),
        .run_n_standby(link_if.run_n_standby), .core_pwr_ok, .pump_out, .pump_oe,
        .booster_out, .booster_oe, .unlock_flag, .divided_vco_pulse, .divided_ref_pulse);
    // =====================================================
    // verdict and comparison
    task test_done;
        if (num_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task timeout(input string what);
        num_errors++;
        $display("wrong value %s expected done seen timeout", what);
        test_done;
    endtask
    // =====================================================
    // one apb transfer; read data taken at the pready edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        for (int i = 0; i <= 20; i++) begin
            @(posedge core_clk);
            if (pready === 1'h1) break;
            if (i == 20) timeout("apb ready");
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // load a word, start the link, poll busy until it clears
    task send(input logic [23:0] w);
        apb(1'h1, REG_TXWORD, {8'h00, w});
        apb(1'h1, REG_CTRL, 32'h3);
        for (int i = 0; i <= 300; i++) begin
            apb(1'h0, REG_STATUS, 32'h0);
            if (rd[STAT_BUSY] === 1'h0) break;
            if (i == 300) timeout("link busy");
        end
    endtask
    // cycles until the next divider pulse land in n
    task pulse(input logic vco);
        n = 0;
        for (int i = 0; i <= 20000; i++) begin
            @(posedge core_clk);
            n++;
            if ((vco ? divided_vco_pulse : divided_ref_pulse) === 1'h1) break;
            if (i == 20000) timeout("divider pulse");
        end
    endtask
    // third interval, so a new ratio has surely been loaded
    task period(input logic vco, input int exp, input string what);
        pulse(vco);
        pulse(vco);
        pulse(vco);
        check(what, n, exp);
    endtask
    task wait_oe(input logic lvl, input int lim, input string what);
        n = 0;
        while (booster_oe !== lvl && n < lim) begin
            @(posedge core_clk);
            n++;
        end
        check(what, {31'h0, booster_oe}, {31'h0, lvl});
    endtask
    function automatic logic [23:0] vword(logic [11:0] m, logic [4:0] s, logic [4:0] b);
        return {m, s, b, SEL_NDIV};
    endfunction
    function automatic logic [23:0] rword(logic [15:0] b, logic en);
        return {b, 3'h0, en, 2'h0, SEL_RDIV};
    endfunction
    // =====================================================
    // main sequence
    initial begin
        repeat (4) @(posedge core_clk);
        resetn <= 1'h1;
        apb(1'h0, REG_CTRL, 32'h0);
        check("ctrl reset", rd, 32'h0);
        apb(1'h0, 8'h0c, 32'h0);
        check("unmapped err", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
        apb(1'h1, REG_TXWORD, 32'hff123456);
        apb(1'h0, REG_TXWORD, 32'h0);
        check("txword", rd, 32'h00123456);
        apb(1'h1, REG_CTRL, 32'h2);
        period(1'h0, 160, "ref default");
        send(rword(16'h0007, 1'h0));
        period(1'h0, 224, "ref b7");
        // selector codes 10 and 11 load no latch
        send({16'h0009, 6'h00, 2'h2});
        send({16'h0009, 6'h00, 2'h3});
        period(1'h0, 224, "ref unused sel");
        send(vword(12'h021, 5'h1f, 5'h00));
        repeat (400) @(posedge core_clk);
        check("booster idle", {31'h0, booster_oe}, 32'h0);
        period(1'h1, 8696, "vco 33 31");
        send(vword(12'h020, 5'h00, 5'h03));
        wait_oe(1'h1, 40, "booster on");
        wait_oe(1'h0, 2000, "booster released");
        // matched ratios 1024 and 4*256 restart in phase from standby
        send(rword(16'h0100, 1'h1));
        apb(1'h1, REG_CTRL, 32'h0);
        repeat (8) @(posedge core_clk);
        check("standby", {29'h0, pump_oe, booster_oe, unlock_flag}, 32'h0);
        apb(1'h1, REG_CTRL, 32'h2);
        wait_oe(1'h1, 40, "booster run rise");
        pulse(1'h0);
        pulse(1'h0);
        pulse(1'h0);
        check("locked", {31'h0, unlock_flag}, 32'h1);
        pulse(1'h0);
        check("ref kept", n, 8192);
        send(rword(16'h0100, 1'h0));
        repeat (4) @(posedge core_clk);
        check("unlock off", {31'h0, unlock_flag}, 32'h0);
        // core power loss acts as standby; its return is a run rise
        core_pwr_ok <= 1'h0;
        repeat (8) @(posedge core_clk);
        core_pwr_ok <= 1'h1;
        wait_oe(1'h1, 40, "booster power back");
        core_pwr_ok <= 1'h0;
        repeat (8) @(posedge core_clk);
        check("no core power", {31'h0, booster_oe}, 32'h0);
        test_done;
    end
endmodule // test_pll_divider_serial_control
